// [rtl/mcu_interrupt_controller.sv]
// Purpose: vectored interrupt controller with call stack and APB registers
// Assumes: core raises instrBoundary between instructions
// Notes: APB answers with no wait states
`timescale 1ns/1ps
`default_nettype none
// How it works
// - timer-3 A flag at bit 5, enable bit 1; bits 7:6, 3:2 read zero.
// - timer-3 P flag at bit 4, enable bit 0; all reset to zero.
// - source events set their flag regardless of the enable.
// - a vector is taken only when its enable bit is one.
// - global enable low blocks every interrupt; flags still set.
// - acknowledge pushes the next pc and loads the vector address.
// - return from interrupt pops the saved pc.
// - servicing clears the global enable, preventing nesting.
// - requests while blocked keep their flags for later service.
// - no acknowledge while the stack is full.
// - simultaneous requests are served in fixed priority order.
// - a flag becoming set wakes from sleep or idle; old flags do not.
// - pin transition of the selected type sets that pin's flag.
// - pin vector needs global enable and that pin's enable.
// - servicing a pin vector clears that pin's flag and global enable.
// - edge select picks rising, falling, both, or off per pin.
// - a comparator output change sets that comparator's flag.
// - comparator vector needs global enable and its enable bit.
// - servicing a comparator clears its flag and the global enable.
// - shared flag sets when a grouped source flag with its enable one sets; service clears it.
module mcu_interrupt_controller #(
	parameter int PCW = intc_pkg::PCW,
	parameter int STACK_DEPTH = intc_pkg::STACK_DEPTH,
	parameter logic [intc_pkg::NSRC*intc_pkg::VW-1:0] PRIO_ORDER =
		intc_pkg::PRIO_DEFAULT
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [intc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instrBoundary,
	input wire logic [PCW-1:0] pcNext,
	input wire logic callExec,
	input wire logic retExec,
	input wire logic returnFromInterrupt,
	input wire logic lowPower,
	input wire logic timer3CmpA,
	input wire logic timer3CmpP,
	input wire logic [1:0] cmpOut,
	input wire logic [3:0] externalInterruptPins,
	output logic intAck,
	output logic pcLoadValid,
	output logic [PCW-1:0] pcLoadAddr,
	output logic stackFull,
	output logic wakeUp
);
	localparam int VW = intc_pkg::VW;
	localparam int NSRC = intc_pkg::NSRC;
	localparam int SPW = $clog2(STACK_DEPTH + 1);
	localparam logic [SPW-1:0] SP_FULL = SPW'(STACK_DEPTH);

	typedef struct packed {
		logic gie;
		logic [1:0] t3Flag;
		logic [1:0] t3En;
		logic [3:0] extFlag;
		logic [3:0] extEn;
		logic [7:0] edgeSel;
		logic [1:0] cpFlag;
		logic [1:0] cpEn;
		logic mfFlag;
		logic mfEn;
		logic [1:0] cmpS1;
		logic [1:0] cmpS2;
		logic [1:0] cmpPrev;
		logic [SPW-1:0] sp;
		logic [STACK_DEPTH-1:0][PCW-1:0] stack;
		logic pcLoadValid;
		logic [PCW-1:0] pcLoadAddr;
		logic [VW-1:0] lastVec;
		logic wake;
		logic [31:0] rdata;
	} ctrl_state_t;
	ctrl_state_t q, d;

	logic [3:0] extHit;
	logic [NSRC-1:0] pend;
	logic anyPend;
	logic [VW-1:0] selVec;
	logic take;
	logic full;
	logic wrEn;
	logic [1:0] t3Set;
	logic [1:0] cpSet;
	logic mfSet;

	function automatic logic isMapped(input logic [intc_pkg::ADDR_W-1:0] a);
		return a == intc_pkg::OFS_CTRL || a == intc_pkg::OFS_T3 ||
			a == intc_pkg::OFS_EXT || a == intc_pkg::OFS_EDGE ||
			a == intc_pkg::OFS_CMP || a == intc_pkg::OFS_MF ||
			a == intc_pkg::OFS_STAT;
	endfunction : isMapped

	pin_edge_detect #(
		.N(4)
	) u_edge (
		.clk(clk),
		.srst(srst),
		.pin(externalInterruptPins),
		.sel(q.edgeSel),
		.hit(extHit)
	);

	prio_pick #(
		.N(NSRC),
		.W(VW),
		.ORDER(PRIO_ORDER)
	) u_prio (
		.req(pend),
		.any(anyPend),
		.idx(selVec)
	);

	assign full = q.sp == SP_FULL;
	assign t3Set = {timer3CmpA, timer3CmpP};
	assign cpSet = q.cmpS2 ^ q.cmpPrev;
	assign mfSet = |(t3Set & q.t3En);
	// bit i of pend belongs to vector i
	assign pend = {q.mfFlag & q.mfEn, q.cpFlag & q.cpEn,
		q.extFlag & q.extEn};
	// call or return in the same cycle owns the stack, so wait a boundary
	assign take = instrBoundary & q.gie & anyPend & ~full &
		~(callExec | retExec | returnFromInterrupt);
	assign wrEn = psel & penable & pwrite & isMapped(paddr);

	always_comb begin
		logic [31:0] rd;
		rd = '0;
		d = q;
		d.pcLoadValid = 1'b0;
		d.cmpS1 = cmpOut;
		d.cmpS2 = q.cmpS1;
		d.cmpPrev = q.cmpS2;
		if (wrEn) begin
			unique case (paddr)
				intc_pkg::OFS_CTRL: d.gie = pwdata[intc_pkg::GIE_BIT];
				intc_pkg::OFS_T3: begin
					d.t3Flag = {pwdata[intc_pkg::T3_AF_BIT],
						pwdata[intc_pkg::T3_PF_BIT]};
					d.t3En = {pwdata[intc_pkg::T3_AE_BIT],
						pwdata[intc_pkg::T3_PE_BIT]};
				end
				intc_pkg::OFS_EXT: begin
					d.extFlag = pwdata[intc_pkg::FLAG_LSB +: 4];
					d.extEn = pwdata[intc_pkg::EN_LSB +: 4];
				end
				intc_pkg::OFS_EDGE: d.edgeSel = pwdata[7:0];
				intc_pkg::OFS_CMP: begin
					d.cpFlag = pwdata[intc_pkg::FLAG_LSB +: 2];
					d.cpEn = pwdata[intc_pkg::EN_LSB +: 2];
				end
				intc_pkg::OFS_MF: begin
					d.mfFlag = pwdata[intc_pkg::FLAG_LSB];
					d.mfEn = pwdata[intc_pkg::EN_LSB];
				end
				default: begin
				end
			endcase
		end
		if (take) begin
			d.gie = 1'b0;
			d.lastVec = selVec;
			if (selVec < intc_pkg::VEC_CP0) begin
				d.extFlag[selVec[1:0]] = 1'b0;
			end else if (selVec < intc_pkg::VEC_MF) begin
				d.cpFlag[selVec[0]] = 1'b0;
			end else begin
				d.mfFlag = 1'b0;
			end
			d.stack[q.sp] = pcNext;
			d.sp = SPW'(q.sp + 1'b1);
			d.pcLoadValid = 1'b1;
			d.pcLoadAddr = intc_pkg::vecAddr(selVec);
		end else if (retExec | returnFromInterrupt) begin
			// popping an empty stack is ignored
			if (q.sp != '0) begin
				d.sp = SPW'(q.sp - 1'b1);
				d.pcLoadValid = 1'b1;
				d.pcLoadAddr = q.stack[SPW'(q.sp - 1'b1)];
			end
		end else if (callExec) begin
			// overflow silently drops the address, as the core would
			if (!full) begin
				d.stack[q.sp] = pcNext;
				d.sp = SPW'(q.sp + 1'b1);
			end
		end
		// hardware sets land last so they win over any clear
		d.t3Flag = d.t3Flag | t3Set;
		d.extFlag = d.extFlag | extHit;
		d.cpFlag = d.cpFlag | cpSet;
		d.mfFlag = d.mfFlag | mfSet;
		// only new events wake, so a flag already set stays quiet
		d.wake = lowPower & |{t3Set, extHit, cpSet, mfSet};
		unique case (paddr)
			intc_pkg::OFS_CTRL: rd[intc_pkg::GIE_BIT] = q.gie;
			intc_pkg::OFS_T3: begin
				rd[intc_pkg::T3_AF_BIT] = q.t3Flag[1];
				rd[intc_pkg::T3_PF_BIT] = q.t3Flag[0];
				rd[intc_pkg::T3_AE_BIT] = q.t3En[1];
				rd[intc_pkg::T3_PE_BIT] = q.t3En[0];
			end
			intc_pkg::OFS_EXT: begin
				rd[intc_pkg::FLAG_LSB +: 4] = q.extFlag;
				rd[intc_pkg::EN_LSB +: 4] = q.extEn;
			end
			intc_pkg::OFS_EDGE: rd[7:0] = q.edgeSel;
			intc_pkg::OFS_CMP: begin
				rd[intc_pkg::FLAG_LSB +: 2] = q.cpFlag;
				rd[intc_pkg::EN_LSB +: 2] = q.cpEn;
			end
			intc_pkg::OFS_MF: begin
				rd[intc_pkg::FLAG_LSB] = q.mfFlag;
				rd[intc_pkg::EN_LSB] = q.mfEn;
			end
			intc_pkg::OFS_STAT: begin
				rd[intc_pkg::STAT_SP_LSB +: SPW] = q.sp;
				rd[intc_pkg::STAT_VEC_LSB +: VW] = q.lastVec;
				rd[intc_pkg::STAT_FULL_BIT] = full;
			end
			default: rd = '0;
		endcase
		// sampled in setup so the access phase shows stable data
		if (psel & ~penable) begin
			d.rdata = rd;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~isMapped(paddr);
	assign intAck = take;
	assign pcLoadValid = q.pcLoadValid;
	assign pcLoadAddr = q.pcLoadAddr;
	assign stackFull = full;
	assign wakeUp = q.wake;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	gie_clear_a: assert property (intAck |=> !q.gie)
		else $error("global enable survived an acknowledge");
	gie_block_a: assert property (intAck |-> q.gie)
		else $error("interrupt taken with global enable low");
	full_block_a: assert property (full |-> !intAck)
		else $error("interrupt taken with a full stack");
	boundary_a: assert property (intAck |-> instrBoundary)
		else $error("interrupt taken inside an instruction");
	vector_load_a: assert property (intAck |=>
		pcLoadValid && pcLoadAddr == intc_pkg::vecAddr($past(selVec)))
		else $error("vector address not loaded after acknowledge");
	push_pc_a: assert property (intAck |=>
		q.stack[$past(q.sp)] == $past(pcNext) &&
		q.sp == SPW'($past(q.sp) + 1'b1))
		else $error("pc not pushed on acknowledge");
	return_from_interrupt_pop_a: assert property (returnFromInterrupt && q.sp != '0 |=>
		pcLoadValid &&
		pcLoadAddr == $past(q.stack[SPW'(q.sp - 1'b1)]))
		else $error("return did not restore the saved pc");
	flag_set_a: assert property (timer3CmpA && !q.t3En[1] |=>
		q.t3Flag[1] [*2])
		else $error("timer-3 A event lost or flag unstable");
	enable_need_a: assert property (intAck |->
		pend[selVec] && (selVec != intc_pkg::VEC_MF || q.mfEn))
		else $error("vector taken without its enable");
	ext_clear_a: assert property (intAck &&
		selVec < intc_pkg::VEC_CP0 && !extHit[selVec[1:0]] |=>
		!q.extFlag[$past(selVec[1:0])])
		else $error("pin flag not cleared by service");
	wake_new_a: assert property (wakeUp |-> $past(lowPower))
		else $error("wake outside low power");
	reserved_zero_a: assert property (psel && penable &&
		paddr == intc_pkg::OFS_T3 |-> prdata[7:6] == 2'h0 &&
		prdata[3:2] == 2'h0)
		else $error("unimplemented bits read nonzero");

	// flag upkeep, vector choice and stack bounds
	mf_clear_a: assert property (intAck &&
		selVec == intc_pkg::VEC_MF && !mfSet |=> !q.mfFlag)
		else $error("shared flag not cleared by service");
	mf_set_a: assert property (mfSet |=> q.mfFlag)
		else $error("shared flag missed a grouped event");
	cp_clear_a: assert property (intAck &&
		selVec >= intc_pkg::VEC_CP0 && selVec < intc_pkg::VEC_MF &&
		!cpSet[selVec[0]] |=> !q.cpFlag[$past(selVec[0])])
		else $error("comparator flag not cleared by service");
	flag_keep_a: assert property (!q.gie && q.extFlag[0] &&
		!wrEn |=> q.extFlag[0])
		else $error("pin flag lost while interrupts blocked");
	cp_set_a: assert property (cpSet[0] |=> q.cpFlag[0])
		else $error("comparator change not flagged");
	pin_set_a: assert property (extHit != 4'h0 |=>
		(q.extFlag & $past(extHit)) == $past(extHit))
		else $error("pin edge not flagged");
	t3p_set_a: assert property (timer3CmpP |=> q.t3Flag[0])
		else $error("timer-3 P event lost");
	prio_first_a: assert property (intAck &&
		pend[PRIO_ORDER[VW-1:0]] |-> selVec == PRIO_ORDER[VW-1:0])
		else $error("top priority vector passed over");
	ext_need_a: assert property (intAck &&
		selVec < intc_pkg::VEC_CP0 |-> q.extEn[selVec[1:0]] && q.gie)
		else $error("pin vector taken without its enable");
	cp_need_a: assert property (intAck &&
		selVec >= intc_pkg::VEC_CP0 && selVec < intc_pkg::VEC_MF |->
		q.cpEn[selVec[0]] && q.gie)
		else $error("comparator vector taken without its enable");
	edge_off_a: assert property (
		q.edgeSel[1:0] == intc_pkg::EDGE_OFF |-> !extHit[0])
		else $error("disabled pin still triggers");
	wake_event_a: assert property (lowPower &&
		extHit != 4'h0 |=> wakeUp)
		else $error("new pin event did not wake");
	pop_sp_a: assert property (retExec && q.sp != '0 |=>
		q.sp == SPW'($past(q.sp) - 1'b1))
		else $error("return did not pop the stack");
	ack_once_a: assert property (intAck |=> !intAck)
		else $error("second acknowledge without software enable");
	sp_limit_a: assert property (q.sp <= SP_FULL)
		else $error("stack pointer beyond its depth");
endmodule : mcu_interrupt_controller
`default_nettype wire

// [rtl/intc_pkg.sv]
// Purpose: shared constants of the interrupt controller
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package intc_pkg;
	localparam int PCW = 12;
	localparam int STACK_DEPTH = 12;
	localparam int NSRC = 7;
	localparam int VW = 3;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_T3 = 8'h04;
	localparam logic [7:0] OFS_EXT = 8'h08;
	localparam logic [7:0] OFS_EDGE = 8'h0c;
	localparam logic [7:0] OFS_CMP = 8'h10;
	localparam logic [7:0] OFS_MF = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam int GIE_BIT = 0;
	localparam int T3_AF_BIT = 5;
	localparam int T3_PF_BIT = 4;
	localparam int T3_AE_BIT = 1;
	localparam int T3_PE_BIT = 0;
	localparam int FLAG_LSB = 4;
	localparam int EN_LSB = 0;
	localparam int STAT_SP_LSB = 0;
	localparam int STAT_VEC_LSB = 4;
	localparam int STAT_FULL_BIT = 8;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [VW-1:0] VEC_EXT0 = 3'h0;
	localparam logic [VW-1:0] VEC_CP0 = 3'h4;
	localparam logic [VW-1:0] VEC_MF = 3'h6;
	localparam logic [PCW-1:0] VEC_BASE = 12'h004;
	localparam logic [PCW-1:0] VEC_STEP = 12'h004;
	// position 0 of the list is served first
	localparam logic [NSRC*VW-1:0] PRIO_DEFAULT =
		{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

	function automatic logic [PCW-1:0] vecAddr(input logic [VW-1:0] idx);
		return PCW'(VEC_BASE + (VEC_STEP * PCW'(idx)));
	endfunction : vecAddr
endpackage : intc_pkg

// [rtl/pin_edge_detect.sv]
// Purpose: synchronise external pins and flag selected transitions
// Assumes: pins are asynchronous to clk
// Notes: hit is a one-cycle pulse per pin
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect #(
	parameter int N = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [N-1:0] pin,
	input wire logic [2*N-1:0] sel,
	output logic [N-1:0] hit
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] prev;
	} edge_state_t;
	edge_state_t q, d;

	always_comb begin
		d = q;
		hit = '0;
		d.s1 = pin;
		d.s2 = q.s1;
		d.prev = q.s2;
		for (int i = 0; i < N; i++) begin
			unique case (sel[2*i +: 2])
				intc_pkg::EDGE_RISE: hit[i] = q.s2[i] & ~q.prev[i];
				intc_pkg::EDGE_FALL: hit[i] = ~q.s2[i] & q.prev[i];
				intc_pkg::EDGE_BOTH: hit[i] = q.s2[i] ^ q.prev[i];
				intc_pkg::EDGE_OFF: hit[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : pin_edge_detect
`default_nettype wire

// [rtl/prio_pick.sv]
// Purpose: fixed-order pick of one pending vector
// Assumes: ORDER lists vector numbers, lowest slot served first
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module prio_pick #(
	parameter int N = 7,
	parameter int W = 3,
	parameter logic [N*W-1:0] ORDER = intc_pkg::PRIO_DEFAULT
) (
	input wire logic [N-1:0] req,
	output logic any,
	output logic [W-1:0] idx
);
	always_comb begin
		logic [W-1:0] v;
		v = '0;
		any = 1'b0;
		idx = '0;
		// walk from lowest priority up so the best slot writes last
		for (int k = N - 1; k >= 0; k--) begin
			v = ORDER[k*W +: W];
			if (req[v]) begin
				any = 1'b1;
				idx = v;
			end
		end
	end
endmodule : prio_pick
`default_nettype wire

// [dv/core_model.sv]
// Purpose: program sequencer of the core, seen from the controller
// Assumes: every instruction takes two cycles
// Notes: pc follows any load the controller issues
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic pcLoadValid,
	input wire logic [11:0] pcLoadAddr,
	output logic instrBoundary,
	output logic [11:0] pcNext
);
	// boundary only every other cycle, so takes must wait for it
	always_ff @(posedge clk) begin
		if (srst) begin
			instrBoundary <= 1'h0;
			pcNext <= 12'h100;
		end else begin
			instrBoundary <= ~instrBoundary;
			if (pcLoadValid) begin
				pcNext <= pcLoadAddr;
			end else begin
				pcNext <= pcNext + 12'(instrBoundary);
			end
		end
	end
endmodule : core_model
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: register and vectoring tests of the interrupt controller
// Assumes: zero wait apb, vector address 4 + 4 * number
// Notes: software duties are done by the test sequence
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, ib, intAck, pcLoadValid, stackFull, wakeUp;
	logic callExec = 1'h0, retExec = 1'h0, return_from_interrupt = 1'h0;
	logic lowPower = 1'h0, tA = 1'h0, tP = 1'h0, perr;
	logic [1:0] cmpOut = 2'h0;
	logic [3:0] pins = 4'h0;
	logic [11:0] pcNext, pcLoadAddr, savedPc;
	int errors = 0, checks = 0, acks = 0, wakes = 0, loads = 0;
	always #2.5 clk = ~clk;
	core_model core (.clk(clk), .srst(srst), .pcLoadValid(pcLoadValid),
		.pcLoadAddr(pcLoadAddr), .instrBoundary(ib), .pcNext(pcNext));
	mcu_interrupt_controller uut (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instrBoundary(ib), .pcNext(pcNext),
		.callExec(callExec), .retExec(retExec),
		.returnFromInterrupt(return_from_interrupt), .lowPower(lowPower),
		.timer3CmpA(tA), .timer3CmpP(tP), .cmpOut(cmpOut),
		.externalInterruptPins(pins), .intAck(intAck),
		.pcLoadValid(pcLoadValid), .pcLoadAddr(pcLoadAddr),
		.stackFull(stackFull), .wakeUp(wakeUp));
	always @(posedge clk) begin
		if (intAck === 1'h1) begin
			acks <= acks + 1;
			savedPc <= pcNext;
		end
		if (wakeUp === 1'h1) begin
			wakes <= wakes + 1;
		end
		if (pcLoadValid === 1'h1) begin
			loads <= loads + 1;
		end
	end
	task summarize;
		if (errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
	task step(input int n);
		repeat (n) @(posedge clk);
	endtask : step
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'h0;
		xfer(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		xfer(1'h1, 8'h04, 32'hcc);
		xfer(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		xfer(1'h1, 8'h00, 32'h1);
		lowPower <= 1'h1;
		@(posedge clk) tA <= 1'h1;
		@(posedge clk) tA <= 1'h0;
		step(4);
		lowPower <= 1'h0;
		chk(wakes, 1);
		chk(acks, 0);
		xfer(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h20);
		xfer(1'h1, 8'h04, 32'h0);
		xfer(1'h1, 8'h00, 32'h0);
		xfer(1'h1, 8'h10, 32'h1);
		cmpOut <= 2'h1;
		step(8);
		xfer(1'h0, 8'h10, 32'h0);
		chk(rd, 32'h11);
		chk(acks, 0);
		xfer(1'h1, 8'h00, 32'h1);
		step(8);
		chk(acks, 1);
		chk(32'(pcLoadAddr), 32'h14);
		xfer(1'h0, 8'h10, 32'h0);
		chk(rd, 32'h1);
		xfer(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		@(posedge clk) return_from_interrupt <= 1'h1;
		@(posedge clk) return_from_interrupt <= 1'h0;
		step(4);
		chk(32'(pcLoadAddr), 32'(savedPc));
		// pin 0 both edges, pin 1 rising, pin 2 off
		xfer(1'h1, 8'h0c, 32'h07);
		xfer(1'h1, 8'h08, 32'h03);
		xfer(1'h1, 8'h10, 32'h3);
		cmpOut <= 2'h3;
		pins <= 4'h2;
		step(8);
		chk(acks, 1);
		xfer(1'h1, 8'h00, 32'h1);
		step(8);
		chk(32'(pcLoadAddr), 32'h8);
		xfer(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h03);
		xfer(1'h1, 8'h00, 32'h1);
		step(8);
		chk(32'(pcLoadAddr), 32'h18);
		pins <= 4'h3;
		step(8);
		xfer(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h13);
		xfer(1'h1, 8'h08, 32'h03);
		pins <= 4'h6;
		step(8);
		xfer(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h13);
		// two frames already stacked, ten calls fill it
		repeat (10) begin
			@(posedge clk) callExec <= 1'h1;
			@(posedge clk) callExec <= 1'h0;
		end
		step(2);
		chk({31'h0, stackFull}, 32'h1);
		xfer(1'h1, 8'h00, 32'h1);
		step(8);
		chk(acks, 3);
		@(posedge clk) retExec <= 1'h1;
		@(posedge clk) retExec <= 1'h0;
		step(8);
		chk(acks, 4);
		chk(32'(pcLoadAddr), 32'h4);
		// shared vector: timer-3 P event with its enable and the shared one
		@(posedge clk) return_from_interrupt <= 1'h1;
		@(posedge clk) return_from_interrupt <= 1'h0;
		xfer(1'h1, 8'h04, 32'h01);
		xfer(1'h1, 8'h14, 32'h01);
		@(posedge clk) tP <= 1'h1;
		@(posedge clk) tP <= 1'h0;
		xfer(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h11);
		xfer(1'h0, 8'h14, 32'h0);
		chk(rd, 32'h11);
		xfer(1'h1, 8'h00, 32'h1);
		step(8);
		chk(32'(pcLoadAddr), 32'h1c);
		xfer(1'h0, 8'h14, 32'h0);
		chk(rd, 32'h01);
		xfer(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h11);
		xfer(1'h0, 8'h18, 32'h0);
		chk(rd, 32'h16c);
		chk({31'h0, perr}, 32'h0);
		xfer(1'h0, 8'h1c, 32'h0);
		chk({31'h0, perr}, 32'h1);
		chk(rd, 32'h0);
		chk(acks, 5);
		chk(loads, 8);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
